// *** logic/evc_top.sv ***
// event capture unit: four timestamps per sequence, or a single pwm output
// assumes strobe register port in mclk domain, pin and sync_in synchronous
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module evc_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire logic        pin_in,
  input  wire logic        sync_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             irq
);
  logic [31:0] time_base_count_reg;
  logic [31:0] phase_reg;
  logic [31:0] capture_reg_one_reg;
  logic [31:0] capture_reg_two_reg;
  logic [31:0] capture_reg_three_reg;
  logic [31:0] capture_reg_four_reg;
  logic [13:0] control_reg_one_reg;
  logic [10:0] control_reg_two_reg;
  logic [7:0]  event_enable_reg;
  logic [7:0]  event_flag_reg;
  logic [7:0]  event_flag_next;
  logic [1:0]  event_sequencer_reg;
  logic        armed_reg;
  logic [3:0]  capture_load_strobes_reg;
  logic        pre_prev_reg;
  logic        pin_out_reg;
  logic        pin_oe_n_reg;
  logic        irq_reg;
  logic [31:0] rdata_reg;

  logic wr_count;
  logic wr_phase;
  logic wr_capture_reg_one;
  logic wr_capture_reg_two;
  logic wr_capture_reg_three;
  logic wr_capture_reg_four;
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_ena;
  logic wr_clr;
  logic wr_frc;

  logic        aux_pwm_mode;
  logic        pwm_output_polarity;
  logic        capture_load_enable;
  logic        one_shot;
  logic        count_run;
  logic [1:0]  stop_value;
  logic [3:0]  edge_polarity;
  logic [3:0]  counter_reset_sel;
  logic [4:0]  prescale_sel;
  logic        rearm;
  logic        sync_hit;
  logic        pre_sig;
  logic        rise_edge;
  logic        fall_edge;
  logic        edge_hit;
  logic        capture_event;
  logic        stop_hit;
  logic [3:0]  event_onehot;
  logic        counter_clear;
  logic        period_match;
  logic        compare_match;
  logic        counter_overflow_event;
  logic        irq_fire;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;

  // register port write decode
  assign wr_count = wr_en && (addr == evc_pkg::OFF_COUNT);
  assign wr_phase = wr_en && (addr == evc_pkg::OFF_PHASE);
  assign wr_capture_reg_one  = wr_en && (addr == evc_pkg::OFF_CAPTURE_REG_ONE);
  assign wr_capture_reg_two  = wr_en && (addr == evc_pkg::OFF_CAPTURE_REG_TWO);
  assign wr_capture_reg_three  = wr_en && (addr == evc_pkg::OFF_CAPTURE_REG_THREE);
  assign wr_capture_reg_four  = wr_en && (addr == evc_pkg::OFF_CAPTURE_REG_FOUR);
  assign wr_ctl1  = wr_en && (addr == evc_pkg::OFF_CTL1);
  assign wr_ctl2  = wr_en && (addr == evc_pkg::OFF_CTL2);
  assign wr_ena   = wr_en && (addr == evc_pkg::OFF_ENA);
  assign wr_clr   = wr_en && (addr == evc_pkg::OFF_CLR);
  assign wr_frc   = wr_en && (addr == evc_pkg::OFF_FRC);

  // control field views
  assign edge_polarity       = control_reg_one_reg[evc_pkg::CR1_POL_LSB +: 4];
  assign counter_reset_sel   = control_reg_one_reg[evc_pkg::CR1_RST_LSB +: 4];
  assign capture_load_enable = control_reg_one_reg[evc_pkg::CR1_LDEN];
  assign prescale_sel = control_reg_one_reg[evc_pkg::CR1_PRE_LSB +: evc_pkg::PRE_W];
  assign one_shot            = control_reg_two_reg[evc_pkg::CR2_ONESHOT];
  assign stop_value          = control_reg_two_reg[evc_pkg::CR2_STOP_LSB +: 2];
  assign count_run           = control_reg_two_reg[evc_pkg::CR2_RUN];
  assign aux_pwm_mode        = control_reg_two_reg[evc_pkg::CR2_PWM];
  assign pwm_output_polarity = control_reg_two_reg[evc_pkg::CR2_POL];
  assign rearm = wr_ctl2 && wdata[evc_pkg::CR2_REARM];

  // hardware sync when enabled, or forced by a control write
  assign sync_hit = (sync_in && control_reg_two_reg[evc_pkg::CR2_SYNCEN])
                  || (wr_ctl2 && wdata[evc_pkg::CR2_SWSYNC]);

  // input divider; pin is only an input outside pwm mode
  evc_prescaler #(
    .SEL_W (evc_pkg::PRE_W)
  ) u_prescaler (
    .mclk    (mclk),
    .reset   (reset),
    .sig_in  (pin_in && !aux_pwm_mode),
    .sel     (prescale_sel),
    .sig_out (pre_sig)
  );

  // edge detect on the prescaled signal
  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_prev_reg <= 1'b0;
    end else begin
      pre_prev_reg <= pre_sig;
    end
  end

  assign rise_edge = pre_sig && !pre_prev_reg;
  assign fall_edge = !pre_sig && pre_prev_reg;
  // polarity chosen by the event slot the sequencer points at
  assign edge_hit  = edge_polarity[event_sequencer_reg] ? fall_edge : rise_edge;
  // continuous mode never freezes, so no armed check there
  assign capture_event = !aux_pwm_mode && (armed_reg || !one_shot) && edge_hit;
  assign stop_hit = capture_event && one_shot
                 && (event_sequencer_reg == stop_value);
  assign event_onehot = capture_event ? (4'h1 << event_sequencer_reg) : 4'h0;

  // event sequencer and one-shot arming
  always_ff @(posedge mclk) begin
    if (reset) begin
      event_sequencer_reg <= 2'h0;
      armed_reg           <= 1'b1;
    end else if (rearm) begin
      event_sequencer_reg <= 2'h0;
      armed_reg           <= 1'b1;
    end else if (stop_hit) begin
      armed_reg           <= 1'b0;
    end else if (capture_event) begin
      event_sequencer_reg <= event_sequencer_reg + 2'h1;
    end
  end

  // load strobes: high one cycle, register loads as the strobe drops
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_load_strobes_reg <= 4'h0;
    end else begin
      capture_load_strobes_reg <= event_onehot & {4{capture_load_enable}};
    end
  end

  // control register one; load enable self-clears on a one-shot stop
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_reg_one_reg <= evc_pkg::CR1_RST;
    end else if (wr_ctl1) begin
      control_reg_one_reg <= wdata[13:0];
    end else if (stop_hit) begin
      control_reg_one_reg[evc_pkg::CR1_LDEN] <= 1'b0;
    end
  end

  // control register two; re-arm and forced sync are not stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_reg_two_reg <= evc_pkg::CR2_RST;
    end else if (wr_ctl2) begin
      control_reg_two_reg <= wdata[10:0];
      control_reg_two_reg[evc_pkg::CR2_REARM]  <= 1'b0;
      control_reg_two_reg[evc_pkg::CR2_SWSYNC] <= 1'b0;
    end
  end

  // phase offset register
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_phase) begin
      phase_reg <= wdata;
    end
  end

  assign counter_clear = |(capture_load_strobes_reg & counter_reset_sel);
  assign period_match  = aux_pwm_mode && (time_base_count_reg == capture_reg_one_reg);
  assign compare_match = aux_pwm_mode && (time_base_count_reg == capture_reg_two_reg);
  // wrap only when the counter runs from CNT_MAX back to zero, not on a period return below it
  assign counter_overflow_event = count_run && !wr_count && !sync_hit && !counter_clear
                               && (time_base_count_reg == evc_pkg::CNT_MAX);

  // time base counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      time_base_count_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_count) begin
      time_base_count_reg <= wdata;
    end else if (sync_hit) begin
      time_base_count_reg <= phase_reg;
    end else if (counter_clear) begin
      time_base_count_reg <= evc_pkg::WORD_ZERO;
    end else if (count_run && period_match) begin
      time_base_count_reg <= evc_pkg::WORD_ZERO;
    end else if (count_run) begin
      time_base_count_reg <= time_base_count_reg + 32'h1;
    end
  end

  // active period / first timestamp
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_reg_one_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_capture_reg_one) begin
      capture_reg_one_reg <= wdata;
    end else if (period_match) begin
      capture_reg_one_reg <= capture_reg_three_reg;
    end else if (capture_load_strobes_reg[0]) begin
      capture_reg_one_reg <= time_base_count_reg;
    end
  end

  // active compare / second timestamp
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_reg_two_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_capture_reg_two) begin
      capture_reg_two_reg <= wdata;
    end else if (period_match) begin
      capture_reg_two_reg <= capture_reg_four_reg;
    end else if (capture_load_strobes_reg[1]) begin
      capture_reg_two_reg <= time_base_count_reg;
    end
  end

  // shadow period / third timestamp; active writes mirror here in pwm
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_reg_three_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_capture_reg_three || (wr_capture_reg_one && aux_pwm_mode)) begin
      capture_reg_three_reg <= wdata;
    end else if (capture_load_strobes_reg[2]) begin
      capture_reg_three_reg <= time_base_count_reg;
    end
  end

  // shadow compare / fourth timestamp
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_reg_four_reg <= evc_pkg::WORD_ZERO;
    end else if (wr_capture_reg_four || (wr_capture_reg_two && aux_pwm_mode)) begin
      capture_reg_four_reg <= wdata;
    end else if (capture_load_strobes_reg[3]) begin
      capture_reg_four_reg <= time_base_count_reg;
    end
  end

  // pwm pin: active while counter is below compare, inverted for active low
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_oe_n_reg <= !aux_pwm_mode;
      if (aux_pwm_mode) begin
        pin_out_reg <= pwm_output_polarity
                     ^ (time_base_count_reg < capture_reg_two_reg);
      end else begin
        pin_out_reg <= 1'b0;
      end
    end
  end

  // event enables
  always_ff @(posedge mclk) begin
    if (reset) begin
      event_enable_reg <= 8'h00;
    end else if (wr_ena) begin
      event_enable_reg <= {wdata[7:1], 1'b0};
    end
  end

  // event set, force and clear terms; set always beats clear
  always_comb begin
    flag_set = 8'h00;
    flag_set[evc_pkg::FLG_CEVT +: 4] = event_onehot;
    flag_set[evc_pkg::FLG_OVF] = counter_overflow_event;
    flag_set[evc_pkg::FLG_PRD] = period_match;
    flag_set[evc_pkg::FLG_CMP] = compare_match;
    if (wr_frc) begin
      flag_set = flag_set | {wdata[7:1], 1'b0};
    end
    flag_set[evc_pkg::FLG_INT] = irq_fire;
    flag_clr = wr_clr ? wdata[7:0] : 8'h00;
    event_flag_next = (event_flag_reg & ~flag_clr) | flag_set;
  end

  // pulse only while the global flag is clear
  assign irq_fire = !event_flag_reg[evc_pkg::FLG_INT]
                 && |(event_flag_reg & event_enable_reg);

  // latched event flags and interrupt pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      event_flag_reg <= 8'h00;
      irq_reg        <= 1'b0;
    end else begin
      event_flag_reg <= event_flag_next;
      irq_reg        <= irq_fire;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (reset || !rd_en) begin
      rdata_reg <= evc_pkg::WORD_ZERO;
    end else begin
      case (addr)
        evc_pkg::OFF_COUNT: rdata_reg <= time_base_count_reg;
        evc_pkg::OFF_PHASE: rdata_reg <= phase_reg;
        evc_pkg::OFF_CAPTURE_REG_ONE:  rdata_reg <= capture_reg_one_reg;
        evc_pkg::OFF_CAPTURE_REG_TWO:  rdata_reg <= capture_reg_two_reg;
        evc_pkg::OFF_CAPTURE_REG_THREE:  rdata_reg <= capture_reg_three_reg;
        evc_pkg::OFF_CAPTURE_REG_FOUR:  rdata_reg <= capture_reg_four_reg;
        evc_pkg::OFF_CTL1:  rdata_reg <= {18'h0, control_reg_one_reg};
        evc_pkg::OFF_CTL2:  rdata_reg <= {21'h0, control_reg_two_reg};
        evc_pkg::OFF_ENA:   rdata_reg <= {24'h0, event_enable_reg};
        evc_pkg::OFF_FLAG:  rdata_reg <= {24'h0, event_flag_reg};
        default:            rdata_reg <= evc_pkg::WORD_ZERO;
      endcase
    end
  end

  assign rdata    = rdata_reg;
  assign pin_out  = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign irq      = irq_reg;

  // checks on the design's own state
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_loaded_event;
    capture_event && capture_load_enable;
  endsequence

  sequence s_strobe_then_load(int idx);
    capture_load_strobes_reg[idx] && !wr_capture_reg_one && !aux_pwm_mode;
  endsequence

  chk_irq_gate: assert property (
    irq |-> $past(!event_flag_reg[0] && |(event_flag_reg & event_enable_reg)))
    else $error("interrupt pulse without an enabled flag or with global set");

  chk_irq_single: assert property (
    irq |=> !irq ##0 (event_flag_reg[0] || $past(wr_clr && wdata[evc_pkg::FLG_INT])))
    else $error("interrupt pulse repeated or global flag not set");

  chk_seq_step: assert property (
    capture_event && !stop_hit && !rearm
    |=> event_sequencer_reg == $past(event_sequencer_reg) + 2'h1)
    else $error("sequencer did not advance by one");

  chk_oneshot_stop: assert property (
    stop_hit && !rearm && !wr_ctl1
    |=> !armed_reg && !capture_load_enable && $stable(event_sequencer_reg))
    else $error("one-shot stop did not freeze the sequence");

  chk_rearm_clear: assert property (
    rearm |=> event_sequencer_reg == 2'h0 && armed_reg)
    else $error("re-arm did not clear the sequencer");

  chk_strobe_route: assert property (
    s_loaded_event |=> capture_load_strobes_reg == $past(event_onehot))
    else $error("load strobe went to the wrong register");

  chk_stamp_value: assert property (
    s_strobe_then_load(0) |=> capture_reg_one_reg == $past(time_base_count_reg))
    else $error("first register did not take the timestamp");

  chk_ctr_reset: assert property (
    counter_clear && !wr_count && !sync_hit |=> time_base_count_reg == 32'h0)
    else $error("counter not cleared after a capture load");

  chk_ovf_flag: assert property (
    counter_overflow_event |=> event_flag_reg[evc_pkg::FLG_OVF])
    else $error("overflow flag not raised on wrap");

  chk_shadow_lock: assert property (
    !aux_pwm_mode && !wr_capture_reg_one && !capture_load_strobes_reg[0] |=> $stable(capture_reg_one_reg))
    else $error("first register changed in capture mode without a load");

  chk_pwm_wrap: assert property (
    count_run && period_match && !wr_count && !sync_hit
    |=> time_base_count_reg == 32'h0)
    else $error("pwm counter did not return to zero after period");

  chk_pwm_level: assert property (
    aux_pwm_mode && !pwm_output_polarity
    |=> pin_out == ($past(time_base_count_reg) < $past(capture_reg_two_reg)))
    else $error("pwm output level wrong for compare value");

  chk_mode_flags: assert property (
    aux_pwm_mode |=> event_flag_reg[4:1] == $past(event_flag_reg[4:1]) || $past(wr_clr || wr_frc))
    else $error("capture flag set in pwm mode");
endmodule : evc_top

// *** common/evc_pkg.sv ***
// constants for the event capture unit with auxiliary pwm mode
// assumes one 100 MHz clock and a plain strobe register port
package evc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_PHASE = 8'h04;
  localparam logic [7:0] OFF_CAPTURE_REG_ONE  = 8'h08;
  localparam logic [7:0] OFF_CAPTURE_REG_TWO  = 8'h0c;
  localparam logic [7:0] OFF_CAPTURE_REG_THREE  = 8'h10;
  localparam logic [7:0] OFF_CAPTURE_REG_FOUR  = 8'h14;
  localparam logic [7:0] OFF_CTL1  = 8'h18;
  localparam logic [7:0] OFF_CTL2  = 8'h1c;
  localparam logic [7:0] OFF_ENA   = 8'h20;
  localparam logic [7:0] OFF_FLAG  = 8'h24;
  localparam logic [7:0] OFF_CLR   = 8'h28;
  localparam logic [7:0] OFF_FRC   = 8'h2c;
  // control_reg_one fields
  localparam int CR1_W       = 14;
  localparam int CR1_POL_LSB = 0;
  localparam int CR1_RST_LSB = 4;
  localparam int CR1_LDEN    = 8;
  localparam int CR1_PRE_LSB = 9;
  localparam int PRE_W       = 5;
  // control_reg_two fields
  localparam int CR2_W        = 11;
  localparam int CR2_ONESHOT  = 0;
  localparam int CR2_STOP_LSB = 1;
  localparam int CR2_REARM    = 3;
  localparam int CR2_RUN      = 4;
  localparam int CR2_SYNCEN   = 5;
  localparam int CR2_SWSYNC   = 6;
  localparam int CR2_PWM      = 9;
  localparam int CR2_POL      = 10;
  // event flag positions
  localparam int FLG_W    = 8;
  localparam int FLG_INT  = 0;
  localparam int FLG_CEVT = 1;
  localparam int FLG_OVF  = 5;
  localparam int FLG_PRD  = 6;
  localparam int FLG_CMP  = 7;
  // reset values and counter maximum
  localparam logic [13:0] CR1_RST   = 14'h0000;
  localparam logic [10:0] CR2_RST   = 11'h010;
  localparam logic [31:0] CNT_MAX   = 32'hffffffff;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
endpackage : evc_pkg

// *** logic/evc_prescaler.sv ***
// even-factor divider for the capture input pulse train
// assumes sig_in is already synchronous to mclk
`timescale 1ns/1ns
module evc_prescaler #(
  parameter int SEL_W = 5
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             sig_in,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  sig_out
);
  logic             prev_reg;
  logic             div_reg;
  logic [SEL_W-1:0] cnt_reg;
  logic             rise;

  assign rise = sig_in & ~prev_reg;

  // toggle once per sel rising edges: one period per 2*sel inputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_reg <= 1'b0;
      div_reg  <= 1'b0;
      cnt_reg  <= '0;
    end else begin
      prev_reg <= sig_in;
      if (sel == '0) begin
        div_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (rise) begin
        if (cnt_reg >= sel - 1'b1) begin
          div_reg <= ~div_reg;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  // zero field bypasses the divider completely
  assign sig_out = (sel == '0) ? sig_in : div_reg;
endmodule : evc_prescaler

// *** verif/evc_pulse_src.sv ***
// pulse train source standing on the capture pin
// assumes the mclk domain; pin held low while disabled
`timescale 1ns/1ns
module evc_pulse_src (
  input  wire logic       mclk,
  input  wire logic       en,
  input  wire logic [7:0] hi_cyc,
  input  wire logic [7:0] lo_cyc,
  output logic            pin
);
  logic [7:0] cnt_reg;

  // count out the high and low phases, then toggle
  always_ff @(posedge mclk) begin
    if (!en) begin
      pin     <= 1'b0;
      cnt_reg <= 8'h01;
    end else if (cnt_reg >= (pin ? hi_cyc : lo_cyc)) begin
      pin     <= ~pin;
      cnt_reg <= 8'h01;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : evc_pulse_src

// *** verif/event_capture_aux_pwm_test.sv ***
// self-checking bench for the event capture unit and its pwm mode
// assumes evc_top alone, with a pulse source model on its pin
`timescale 1ns/1ns
module event_capture_aux_pwm_test;
  logic        mclk    = 1'b0;
  logic        reset   = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        sync_in = 1'b0;
  logic        src_en  = 1'b0;
  logic [7:0]  hi_cyc  = 8'h04;
  logic [7:0]  lo_cyc  = 8'h04;
  logic [31:0] rdata;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe_n;
  logic        irq;
  logic [31:0] rv;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          irq_count  = 0;

  // clock and interrupt pulse tally
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (irq === 1'b1) irq_count <= irq_count + 1;

  evc_top DUT (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in), .sync_in(sync_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq));
  evc_pulse_src src (.mclk(mclk), .en(src_en), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .pin(pin_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic count_high(output logic [31:0] hi);
    hi = 32'h0;
    repeat (5) begin
      @(posedge mclk);
      #1 hi = hi + {31'h0, pin_out};
    end
  endtask : count_high

  task automatic t_reset;
    rd(evc_pkg::OFF_CTL2, rv);
    check("ctl2 reset", rv, 32'h010);
    rd(evc_pkg::OFF_CTL1, rv);
    check("ctl1 reset", rv, 32'h0);
    rd(8'hfc, rv);
    check("unmapped read", rv, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // delta captures over all prescale boundaries, ring of four
  task automatic t_capture;
    int n_tab[4] = '{0, 1, 2, 31};
    int div;
    foreach (n_tab[i]) begin
      div = (n_tab[i] == 0) ? 1 : 2 * n_tab[i];
      wr(evc_pkg::OFF_CTL1, 32'h1f0 | (n_tab[i] << 9));
      src_en <= 1'b1;
      repeat (48 * div + 40) @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
        rd(8'(evc_pkg::OFF_CAPTURE_REG_ONE + 4 * k), rv);
        check("delta capture", rv, 32'(8 * div - 1));
      end
    end
    $display("test capture done");
  endtask : t_capture

  // events two and four on falling edges
  task automatic t_polarity;
    hi_cyc <= 8'h03;
    lo_cyc <= 8'h05;
    wr(evc_pkg::OFF_CTL1, 32'h1fa);
    repeat (200) @(posedge mclk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(evc_pkg::OFF_CAPTURE_REG_ONE + 4 * k), rv);
      check("edge capture", rv, (k % 2) ? 32'h2 : 32'h4);
    end
    $display("test polarity done");
  endtask : t_polarity

  // one-shot stopping after two events
  task automatic t_oneshot;
    src_en <= 1'b0;
    hi_cyc <= 8'h04;
    lo_cyc <= 8'h04;
    wr(evc_pkg::OFF_CTL1, 32'h100);
    wr(evc_pkg::OFF_CAPTURE_REG_THREE, 32'h0);
    wr(evc_pkg::OFF_CLR, 32'hff);
    wr(evc_pkg::OFF_CTL2, 32'h01b);
    src_en <= 1'b1;
    repeat (150) @(posedge mclk);
    rd(evc_pkg::OFF_FLAG, rv);
    check("one-shot flags", rv, 32'h06);
    rd(evc_pkg::OFF_CTL1, rv);
    check("load enable", rv, 32'h0);
    rd(evc_pkg::OFF_CAPTURE_REG_THREE, rv);
    check("frozen capture", rv, 32'h0);
    src_en <= 1'b0;
    $display("test one-shot done");
  endtask : t_oneshot

  // period 4 with compare sweep, both polarities
  task automatic t_pwm;
    int c_tab[5] = '{0, 9, 4, 5, 1};
    int k;
    for (int p = 0; p < 2; p++) begin
      wr(evc_pkg::OFF_CTL2, 32'h210 | (p << 10));
      // bring the counter inside the period, then let the pin toggle in pwm
      wr(evc_pkg::OFF_COUNT, 32'h0);
      wr(evc_pkg::OFF_CLR, 32'hff);
      src_en <= 1'b1;
      foreach (c_tab[i]) begin
        wr(evc_pkg::OFF_CAPTURE_REG_ONE, 32'h4);
        wr(evc_pkg::OFF_CAPTURE_REG_TWO, 32'(c_tab[i]));
        repeat (12) @(posedge mclk);
        count_high(rv);
        k = (c_tab[i] > 5) ? 5 : c_tab[i];
        check("high cycles", rv, 32'(p ? 5 - k : k));
        check("pin drive", {31'h0, pin_oe_n}, 32'h0);
        rd(evc_pkg::OFF_CAPTURE_REG_FOUR, rv);
        check("shadow compare", rv, 32'(c_tab[i]));
      end
    end
    rd(evc_pkg::OFF_FLAG, rv);
    check("match flags", rv & 32'hc0, 32'hc0);
    check("no capture flags", rv & 32'h1e, 32'h0);
    wr(evc_pkg::OFF_CTL2, 32'h210);
    wr(evc_pkg::OFF_CAPTURE_REG_FOUR, 32'h3);
    repeat (12) @(posedge mclk);
    count_high(rv);
    check("shadow transfer", rv, 32'h3);
    src_en <= 1'b0;
    $display("test pwm done");
  endtask : t_pwm

  // interrupt gating, overflow and phase sync
  task automatic t_irq;
    int base;
    logic [31:0] frz;
    wr(evc_pkg::OFF_CTL2, 32'h010);
    // enable register follows the mode one cycle later
    @(posedge mclk);
    #1 check("pin released", {31'h0, pin_oe_n}, 32'h1);
    wr(evc_pkg::OFF_CLR, 32'hff);
    wr(evc_pkg::OFF_ENA, 32'h02);
    base = irq_count;
    wr(evc_pkg::OFF_FRC, 32'h02);
    repeat (5) @(posedge mclk);
    check("first pulse", 32'(irq_count - base), 32'h1);
    wr(evc_pkg::OFF_FRC, 32'h02);
    repeat (5) @(posedge mclk);
    check("held off", 32'(irq_count - base), 32'h1);
    wr(evc_pkg::OFF_CLR, 32'h03);
    wr(evc_pkg::OFF_FRC, 32'h02);
    repeat (5) @(posedge mclk);
    check("after clear", 32'(irq_count - base), 32'h2);
    wr(evc_pkg::OFF_CLR, 32'hff);
    wr(evc_pkg::OFF_COUNT, 32'hfffffff0);
    repeat (30) @(posedge mclk);
    rd(evc_pkg::OFF_FLAG, rv);
    check("overflow flag", rv & 32'h20, 32'h20);
    wr(evc_pkg::OFF_PHASE, 32'h1000);
    wr(evc_pkg::OFF_CTL2, 32'h030);
    sync_in <= 1'b1;
    rd(evc_pkg::OFF_COUNT, rv);
    check("hardware sync", rv, 32'h1000);
    sync_in <= 1'b0;
    // new phase so a missing forced sync cannot land in range
    wr(evc_pkg::OFF_PHASE, 32'h2000);
    wr(evc_pkg::OFF_CTL2, 32'h050);
    rd(evc_pkg::OFF_COUNT, rv);
    check("software sync", {31'h0, rv >= 32'h2000 && rv < 32'h2008}, 32'h1);
    // run bit low holds the counter still
    wr(evc_pkg::OFF_CTL2, 32'h000);
    rd(evc_pkg::OFF_COUNT, frz);
    rd(evc_pkg::OFF_COUNT, rv);
    check("counter frozen", rv, frz);
    $display("test interrupt done");
  endtask : t_irq

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_capture;
    t_polarity;
    t_oneshot;
    t_pwm;
    t_irq;
    give_verdict;
  end
endmodule : event_capture_aux_pwm_test
